// file: design/token_node_pkg.sv
/*
 Package for the token bus node controller: register offsets, reset values, encodings and carrier types.
 Assumes a single 250 MHz clock domain and an AXI4-Lite master with 32-bit data.
*/
`default_nettype none
package token_node_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_PARAM = 8'h08;
   localparam logic [7:0] ADDR_ACTIVE_LO = 8'h0C;
   localparam logic [7:0] ADDR_ACTIVE_HI = 8'h10;
   localparam logic [7:0] ADDR_LINKSET = 8'h14;
   localparam logic [5:0] NODE_MIN = 6'h01;
   localparam logic [5:0] NODE_MAX = 6'h3E;
   localparam logic [7:0] AUX_LINK_WORD = 8'h07;
   localparam logic [7:0] CYCLE_TIME_RST = 8'h00;
   localparam logic [7:0] POLLED_RST = 8'h04;
   localparam logic [7:0] FRAMES_RST = 8'h0A;
   localparam logic [7:0] MAXNODE_RST = 8'h3E;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] LINKSET_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int MASTER_TIMEOUT_NS = 4000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int MASTER_TIMEOUT_CYC = (MASTER_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {MODE_PROGRAM, MODE_MONITOR, MODE_RUN} host_mode_t;
   typedef enum logic [1:0] {ATT_NONE, ATT_CPU_HOSTLINK, ATT_BACKPLANE_LINK} attach_t;
   typedef enum logic [2:0] {ST_IDLE, ST_HOLD, ST_SEND, ST_WAIT, ST_POLL, ST_BCAST} node_state_t;

   typedef struct packed {
      logic [7:0] cycle_time;
      logic [7:0] polled_units;
      logic [7:0] max_frames;
      logic [7:0] max_node;
   } net_param_t;

   // Frame exchanged with the bus transceiver
   typedef struct packed {
      logic token;
      logic data;
      logic poll;
      logic membership;
      logic params;
      logic [5:0] dest;
   } frame_kind_t;

   typedef struct packed {
      logic [3:0] tens;
      logic [3:0] ones;
      logic level_sw;
      logic mode_sw;
      logic console;
      host_mode_t console_mode;
      attach_t attached;
      logic other_sw;
   } straps_t;
endpackage : token_node_pkg
`default_nettype wire

// file: design/token_bus_node_control.sv
/*
 Token bus node controller: token passing, master election and failover, token and polling cycles,
 parameter distribution, node number check, operating level and start-up mode selection, AXI4-Lite registers.
 Assumes a transceiver that moves frames and reports received ones as one-cycle pulses on aclk.
*/
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`default_nettype none
module token_bus_node_control #(
   parameter int TIMEOUT_CYC = token_node_pkg::MASTER_TIMEOUT_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire token_node_pkg::straps_t straps_pin,
   input wire logic rx_valid,
   input wire token_node_pkg::frame_kind_t rx_kind,
   input wire logic [5:0] rx_src,
   input wire logic [63:0] rx_members,
   input wire token_node_pkg::net_param_t rx_param,
   input wire logic tx_done,
   output logic tx_valid,
   output token_node_pkg::frame_kind_t tx_kind,
   output logic [63:0] tx_members,
   output token_node_pkg::net_param_t tx_param,
   output logic comm_error_indicator,
   output logic op_level,
   output token_node_pkg::host_mode_t startup_mode,
   output logic link_running
);
   typedef struct packed {
      token_node_pkg::straps_t sync1;
      token_node_pkg::straps_t sync2;
      token_node_pkg::node_state_t st;
      logic [5:0] my_node;
      logic num_err;
      logic lvl;
      token_node_pkg::host_mode_t mode;
      logic [63:0] active;
      logic [5:0] poll_ix;
      logic is_master;
      logic [31:0] tmo;
      token_node_pkg::net_param_t param;
      logic [31:0] ctrl;
      logic [31:0] linkset;
      logic link_run;
      logic tx_v;
      token_node_pkg::frame_kind_t tx_k;
      logic [7:0] sent;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

   state_t r;
   state_t next_r;

   // Lowest active node number above a given one and not above maxn, or 7'h7F if there is none
   function automatic logic [6:0] next_above(input logic [63:0] act, input logic [5:0] from,
                                             input logic [7:0] maxn);
      logic [6:0] res;
      res = 7'h7F;
      for (int i = 63; i >= 1; i--) begin
         if (act[i] && (6'(i) > from) && (8'(i) <= maxn)) begin
            res = 7'(i);
         end
      end
      return res;
   endfunction : next_above

   logic [6:0] succ;
   logic [6:0] lowest;
   logic [7:0] node_bcd;
   logic [31:0] wmask;
   logic queued;

   always_comb begin
      node_bcd = 8'(r.sync2.tens) * 8'h0A + 8'(r.sync2.ones);
      succ = next_above(r.active, r.my_node, r.param.max_node);
      lowest = next_above(r.active, 6'h00, r.param.max_node);
      wmask = {{8{r.w_strb[3]}}, {8{r.w_strb[2]}}, {8{r.w_strb[1]}}, {8{r.w_strb[0]}}};
      queued = r.ctrl[1] && r.link_run;
   end

   always_comb begin
      next_r = r;
      next_r.sync1 = straps_pin;
      next_r.sync2 = r.sync1;
      next_r.my_node = node_bcd[5:0];
      next_r.num_err = (node_bcd < 8'(token_node_pkg::NODE_MIN)) || (node_bcd > 8'(token_node_pkg::NODE_MAX));
      next_r.lvl = !r.sync2.level_sw;
      // Start-up mode selection
      if (r.sync2.console) begin
         next_r.mode = r.sync2.console_mode;
      end else if (r.sync2.attached == token_node_pkg::ATT_BACKPLANE_LINK) begin
         next_r.mode = (r.sync2.mode_sw || r.sync2.other_sw) ? token_node_pkg::MODE_MONITOR
                                                              : token_node_pkg::MODE_RUN;
      end else if (r.sync2.attached == token_node_pkg::ATT_CPU_HOSTLINK && !r.sync2.mode_sw) begin
         next_r.mode = r.sync2.other_sw ? token_node_pkg::MODE_RUN : token_node_pkg::MODE_PROGRAM;
      end else begin
         next_r.mode = r.sync2.mode_sw ? token_node_pkg::MODE_MONITOR : token_node_pkg::MODE_RUN;
      end
      next_r.active[r.my_node] = !r.num_err;
      next_r.is_master = !r.num_err && (lowest[5:0] == r.my_node);
      next_r.tx_v = r.tx_v && !tx_done;
      // Received frames
      if (rx_valid) begin
         next_r.tmo = 32'h0;
         if (rx_kind.membership) begin
            next_r.active = rx_members;
         end
         if (rx_kind.params && (!r.is_master || rx_src < r.my_node)) begin
            next_r.param = rx_param;
         end
      end else if (tx_done) begin
         // Own frames count as bus traffic, not silence
         next_r.tmo = 32'h0;
      end else if (r.tmo < 32'(TIMEOUT_CYC)) begin
         next_r.tmo = r.tmo + 32'h1;
      end else if (!r.is_master) begin
         next_r.tmo = 32'h0;
         next_r.active[lowest[5:0]] = (lowest[5:0] == r.my_node);
      end
      case (r.st)
         token_node_pkg::ST_IDLE: begin
            if (!r.num_err) begin
               if (r.is_master && r.tmo == 32'(TIMEOUT_CYC)) begin
                  // Silence after an issued token closes the token cycle
                  next_r.st = (r.sent != 8'h0) ? token_node_pkg::ST_POLL : token_node_pkg::ST_HOLD;
               end else if (rx_valid && rx_kind.token && rx_kind.dest == r.my_node) begin
                  next_r.st = (r.is_master && r.sent != 8'h0) ? token_node_pkg::ST_POLL
                                                                : token_node_pkg::ST_HOLD;
               end
            end
         end
         token_node_pkg::ST_HOLD: begin
            if (!r.tx_v) begin
               next_r.tx_v = 1'b1;
               next_r.tx_k = '0;
               if (queued && r.sent < r.param.max_frames) begin
                  next_r.tx_k.data = 1'b1;
                  next_r.sent = r.sent + 8'h1;
                  next_r.st = token_node_pkg::ST_SEND;
               end else begin
                  next_r.tx_k.token = 1'b1;
                  next_r.tx_k.dest = (succ == 7'h7F) ? lowest[5:0] : succ[5:0];
                  if (!r.is_master) begin
                     next_r.sent = 8'h0;
                  end else if (r.sent == 8'h0) begin
                     next_r.sent = 8'h1;
                  end
                  next_r.st = token_node_pkg::ST_WAIT;
               end
            end
         end
         token_node_pkg::ST_SEND: begin
            if (!r.tx_v) begin
               next_r.st = token_node_pkg::ST_HOLD;
            end
         end
         token_node_pkg::ST_WAIT: begin
            if (!r.tx_v) begin
               next_r.st = token_node_pkg::ST_IDLE;
               next_r.poll_ix = 6'h01;
            end
         end
         token_node_pkg::ST_POLL: begin
            if (!r.tx_v) begin
               if (8'(r.poll_ix) > r.param.max_node) begin
                  next_r.st = token_node_pkg::ST_BCAST;
               end else begin
                  next_r.tx_v = 1'b1;
                  next_r.tx_k = '0;
                  next_r.tx_k.poll = 1'b1;
                  next_r.tx_k.dest = r.poll_ix;
                  next_r.poll_ix = r.poll_ix + 6'h1;
               end
            end
         end
         token_node_pkg::ST_BCAST: begin
            if (!r.tx_v) begin
               next_r.tx_v = 1'b1;
               next_r.tx_k = '0;
               next_r.tx_k.membership = 1'b1;
               next_r.tx_k.params = 1'b1;
               next_r.sent = 8'h0;
               next_r.st = token_node_pkg::ST_HOLD;
            end
         end
         default: begin
            next_r.st = token_node_pkg::ST_IDLE;
         end
      endcase
      // Link start from CTRL bits 0 and 2 or a received parameter frame with nonzero cycle_time; stop from CTRL bit 2 alone
      if (r.ctrl[0] && r.ctrl[2]) begin
         next_r.link_run = 1'b1;
      end else if (r.ctrl[2]) begin
         next_r.link_run = 1'b0;
      end else if (rx_valid && rx_kind.params) begin
         next_r.link_run = rx_param.cycle_time != 8'h00 || r.link_run;
      end
      // AXI4-Lite write
      if (s_axi_awvalid && !r.aw_got) begin
         next_r.aw_got = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.w_got) begin
         next_r.w_got = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
      end
      if (r.aw_got && r.w_got && !r.bvalid) begin
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = token_node_pkg::RESP_OKAY;
         if (r.aw_addr == token_node_pkg::ADDR_CTRL) begin
            next_r.ctrl = (r.ctrl & ~wmask) | (r.w_data & wmask);
         end else if (r.aw_addr == token_node_pkg::ADDR_PARAM) begin
            if (r.is_master) begin
               next_r.param = (r.param & ~wmask) | (r.w_data & wmask);
            end
         end else if (r.aw_addr == token_node_pkg::ADDR_LINKSET) begin
            next_r.linkset = (r.linkset & ~wmask) | (r.w_data & wmask);
         end else if (r.aw_addr == token_node_pkg::ADDR_STATUS || r.aw_addr == token_node_pkg::ADDR_ACTIVE_LO
                      || r.aw_addr == token_node_pkg::ADDR_ACTIVE_HI) begin
            next_r.bresp = token_node_pkg::RESP_OKAY;
         end else begin
            next_r.bresp = token_node_pkg::RESP_SLVERR;
         end
      end
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
      end
      // AXI4-Lite read
      next_r.arready = !r.rvalid && !r.arready;
      if (s_axi_arvalid && r.arready) begin
         next_r.arready = 1'b0;
         next_r.rvalid = 1'b1;
         next_r.rresp = token_node_pkg::RESP_OKAY;
         if (s_axi_araddr == token_node_pkg::ADDR_CTRL) begin
            next_r.rdata = r.ctrl;
         end else if (s_axi_araddr == token_node_pkg::ADDR_STATUS) begin
            next_r.rdata = {15'h0, r.st, 2'(r.mode), r.link_run, r.is_master, r.lvl, r.num_err, 2'h0, r.my_node};
         end else if (s_axi_araddr == token_node_pkg::ADDR_PARAM) begin
            next_r.rdata = r.param;
         end else if (s_axi_araddr == token_node_pkg::ADDR_ACTIVE_LO) begin
            next_r.rdata = r.active[31:0];
         end else if (s_axi_araddr == token_node_pkg::ADDR_ACTIVE_HI) begin
            next_r.rdata = r.active[63:32];
         end else if (s_axi_araddr == token_node_pkg::ADDR_LINKSET) begin
            next_r.rdata = r.ctrl[3] ? r.linkset : {24'h0, token_node_pkg::AUX_LINK_WORD};
         end else begin
            next_r.rdata = 32'h0;
            next_r.rresp = token_node_pkg::RESP_SLVERR;
         end
      end
      if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.st <= token_node_pkg::ST_IDLE;
         r.mode <= token_node_pkg::MODE_RUN;
         r.param <= {token_node_pkg::CYCLE_TIME_RST, token_node_pkg::POLLED_RST,
                     token_node_pkg::FRAMES_RST, token_node_pkg::MAXNODE_RST};
         r.ctrl <= token_node_pkg::CTRL_RST;
         r.linkset <= token_node_pkg::LINKSET_RST;
         r.num_err <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign s_axi_awready = !r.aw_got;
   assign s_axi_wready = !r.w_got;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign tx_valid = r.tx_v;
   assign tx_kind = r.tx_k;
   assign tx_members = r.active;
   assign tx_param = r.param;
   assign comm_error_indicator = r.num_err;
   assign op_level = r.lvl;
   assign startup_mode = r.mode;
   assign link_running = r.link_run;
endmodule : token_bus_node_control
`default_nettype wire

// file: test/token_node_monitor.sv
/*
 Checker: bus handshakes, frame holding and strap decode of the node controller.
 Assumes it is bound to the controller top and sees its ports only.
*/
`default_nettype none
module token_node_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire token_node_pkg::straps_t straps_pin,
   input wire logic tx_valid,
   input wire logic tx_done,
   input wire token_node_pkg::frame_kind_t tx_kind,
   input wire logic comm_error_indicator,
   input wire logic op_level,
   input wire token_node_pkg::host_mode_t startup_mode
);
   // ==========
   // Strap settling and decode
   token_node_pkg::straps_t prev;
   token_node_pkg::host_mode_t mode_exp;
   logic [2:0] settle;
   logic [6:0] node;
   always_ff @(posedge aclk) begin
      prev <= straps_pin;
      settle <= (!aresetn || straps_pin != prev) ? 3'h0 : settle + 3'(settle != 3'h7);
   end
   assign node = 7'(straps_pin.tens) * 7'h0A + 7'(straps_pin.ones);
   always_comb begin
      mode_exp = token_node_pkg::MODE_RUN;
      if (straps_pin.console) begin
         mode_exp = straps_pin.console_mode;
      end else if (straps_pin.mode_sw ||
            (straps_pin.other_sw && straps_pin.attached == token_node_pkg::ATT_BACKPLANE_LINK)) begin
         mode_exp = token_node_pkg::MODE_MONITOR;
      end else if (!straps_pin.other_sw && straps_pin.attached == token_node_pkg::ATT_CPU_HOSTLINK) begin
         mode_exp = token_node_pkg::MODE_PROGRAM;
      end
   end
   // ==========
   // Assertions
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
      else $error("write answered early");
   a_frame_hold: assert property (tx_valid && !tx_done |=> tx_valid && $stable(tx_kind))
      else $error("frame withdrawn before done");
   a_node_range: assert property (settle > 3'h5 && straps_pin.tens < 4'hA && straps_pin.ones < 4'hA
      |-> comm_error_indicator == (node == 7'h00 || node > 7'h3E)) else $error("node number check wrong");
   a_level_pick: assert property (settle > 3'h5 |-> op_level == !straps_pin.level_sw)
      else $error("operating level wrong");
   a_mode_pick: assert property (settle > 3'h5 |-> startup_mode == mode_exp)
      else $error("start-up mode wrong");
endmodule : token_node_monitor
bind token_bus_node_control token_node_monitor i_mon (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .straps_pin, .tx_valid, .tx_done, .tx_kind, .comm_error_indicator, .op_level, .startup_mode);
`default_nettype wire

// file: test/peer_nodes_model.sv
/*
 Peer nodes on the bus: end offered frames after a short or long delay, send frames on request.
 Assumes one clock shared with the controller.
*/
`default_nettype none
module peer_nodes_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic slow,
   input wire logic tx_valid,
   input wire token_node_pkg::frame_kind_t tx_kind,
   input wire logic [63:0] tx_members,
   input wire token_node_pkg::net_param_t tx_param,
   output logic tx_done,
   output logic rx_valid,
   output token_node_pkg::frame_kind_t rx_kind,
   output logic [5:0] rx_src,
   output logic [63:0] rx_members,
   output token_node_pkg::net_param_t rx_param
);
   logic [3:0] wait_cnt;
   int frame_cnt = 0;
   token_node_pkg::frame_kind_t last_kind;
   logic [63:0] last_members;
   token_node_pkg::net_param_t last_param;
   initial begin
      tx_done = 1'b0;
      rx_valid = 1'b0;
   end
   // ==========
   // Frame completion, captured at done
   always @(posedge aclk) begin
      tx_done <= 1'b0;
      if (!aresetn) begin
         wait_cnt <= 4'h0;
      end else if (tx_valid && !tx_done) begin
         wait_cnt <= wait_cnt + 4'h1;
         if (wait_cnt == (slow ? 4'h6 : 4'h1)) begin
            tx_done <= 1'b1;
            wait_cnt <= 4'h0;
            frame_cnt <= frame_cnt + 1;
            last_kind <= tx_kind;
            last_members <= tx_members;
            last_param <= tx_param;
         end
      end
   end
   // ==========
   // One received frame; lines inverted once idle
   task automatic send(input logic [10:0] k, input logic [5:0] src, input logic [63:0] mem);
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_kind <= k;
      rx_src <= src;
      rx_members <= mem;
      rx_param <= 32'h2002_0810;
      @(posedge aclk);
      rx_valid <= 1'b0;
      rx_kind <= ~k;
      rx_src <= ~src;
      rx_members <= ~mem;
      rx_param <= ~rx_param;
   endtask : send
endmodule : peer_nodes_model
`default_nettype wire

// file: test/tb_token_bus_node_control.sv
/*
 Bench: registers over AXI4-Lite, strap decode, token passing and master cycle.
 Assumes the controller, its package, the peer model and the checker.
*/
`default_nettype none
module tb_token_bus_node_control;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] PP = 32'h2002_0810;
   localparam logic [10:0] TOK3 = 11'h403, TO7 = 11'h407, TO1 = 11'h401, MEMB = 11'h0FF;
   localparam logic [7:0] NUMS [5] = '{8'h00, 8'h01, 8'h62, 8'h63, 8'h50};
   localparam logic [5:0] BIN [5] = '{6'h00, 6'h01, 6'h3E, 6'h3F, 6'h32};
   localparam logic [4:0] ERRS = 5'b01001;
   logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_valid, tx_done, tx_valid;
   logic comm_error_indicator, op_level, link_running;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [5:0] rx_src, p;
   logic [63:0] rx_members, tx_members;
   token_node_pkg::straps_t straps_pin = 16'h0390, s;
   token_node_pkg::frame_kind_t rx_kind, tx_kind, k;
   token_node_pkg::net_param_t rx_param, tx_param;
   token_node_pkg::host_mode_t startup_mode, m;
   int failures = 0, check_count = 0, nb = 0;
   token_bus_node_control #(.TIMEOUT_CYC(20)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .straps_pin, .rx_valid, .rx_kind, .rx_src, .rx_members, .rx_param, .tx_done, .tx_valid,
      .tx_kind, .tx_members, .tx_param, .comm_error_indicator, .op_level, .startup_mode, .link_running);
   peer_nodes_model i_peer (.aclk, .aresetn, .slow, .tx_valid, .tx_kind, .tx_members, .tx_param, .tx_done,
      .rx_valid, .rx_kind, .rx_src, .rx_members, .rx_param);
   always #2 aclk = ~aclk;
   // ==========
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   task automatic restart(input token_node_pkg::straps_t st);
      @(posedge aclk);
      aresetn <= 1'b0;
      straps_pin <= st;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (8) @(posedge aclk);
   endtask : restart
   task automatic next_frame();
      int c0 = i_peer.frame_cnt;
      while (i_peer.frame_cnt == c0) @(posedge aclk);
      k = i_peer.last_kind;
   endtask : next_frame
   task automatic summarize();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize
   // ==========
   // Tests
   initial begin
      restart(16'h0390);
      axi_rd(token_node_pkg::ADDR_PARAM);
      check(rd, {8'h00, 8'h04, 8'h0A, 8'h3E});
      axi_rd(token_node_pkg::ADDR_LINKSET);
      check(rd, 32'h7);
      axi_rd(8'h40);
      check({rd[29:0], resp}, {30'h0, token_node_pkg::RESP_SLVERR});
      for (int i = 0; i < 5; i++) begin
         s = 16'h0390;
         {s.tens, s.ones} = NUMS[i];
         s.level_sw = i[0];
         restart(s);
         axi_rd(token_node_pkg::ADDR_STATUS);
         check({comm_error_indicator, op_level, rd[9]}, {ERRS[i], !s.level_sw, !s.level_sw});
         if (!ERRS[i]) check(32'(rd[5:0]), 32'(BIN[i]));
      end
      for (int i = 0; i < 15; i++) begin
         s = 16'h0390;
         s.console = i > 11;
         s.console_mode = token_node_pkg::host_mode_t'(i % 3);
         s.attached = token_node_pkg::attach_t'(i % 3);
         s.mode_sw = 1'((i / 3) % 2);
         s.other_sw = 1'(i / 6); // Other unit kept on the other level
         restart(s);
         m = s.console ? s.console_mode
             : (s.mode_sw || (s.other_sw && s.attached == token_node_pkg::ATT_BACKPLANE_LINK))
             ? token_node_pkg::MODE_MONITOR
             : (s.attached == token_node_pkg::ATT_CPU_HOSTLINK && !s.other_sw)
             ? token_node_pkg::MODE_PROGRAM : token_node_pkg::MODE_RUN;
         check(32'(startup_mode), 32'(m));
      end
      restart(16'h0390);
      axi_wr(token_node_pkg::ADDR_CTRL, 32'h8);
      axi_wr(token_node_pkg::ADDR_LINKSET, 32'h1234);
      axi_rd(token_node_pkg::ADDR_LINKSET);
      check(rd, 32'h1234);
      for (int i = 0; i < 3; i++) begin
         axi_wr(token_node_pkg::ADDR_CTRL, 32'(4'h1 + i * 4'h4 - 4'(i / 2) * 4'h5));
         repeat (4) @(posedge aclk);
         check(32'(link_running), 32'(i == 1));
      end
      restart(16'h0390);
      i_peer.send(MEMB, 6'h01, 64'h8A);
      axi_rd(token_node_pkg::ADDR_PARAM);
      check(rd, PP);
      axi_rd(token_node_pkg::ADDR_STATUS);
      check(32'(rd[10]), 32'h0);
      i_peer.send(TOK3, 6'h01, 64'h8A);
      next_frame();
      check(32'(k), 32'(TO7));
      axi_wr(token_node_pkg::ADDR_CTRL, 32'h2);
      i_peer.send(MEMB, 6'h01, 64'h8A);
      i_peer.send(TOK3, 6'h01, 64'h8A);
      next_frame();
      check(32'(k.data), 32'h1);
      while (k.data) next_frame();
      check(32'(k), 32'(TO7));
      axi_wr(token_node_pkg::ADDR_CTRL, 32'h0);
      i_peer.send(MEMB, 6'h01, 64'hA);
      i_peer.send(TOK3, 6'h01, 64'hA);
      next_frame();
      check(32'(k), 32'(TO1));
      slow <= 1'b1;
      next_frame();
      check(32'(k.token), 32'h1);
      while (!k.poll) next_frame();
      check(32'(k.dest), 32'h1);
      while (k.poll) begin
         p = k.dest;
         next_frame();
      end
      check(32'(p), 32'h10);
      while (!k.token) begin
         nb += 32'(k.membership);
         if (k.membership) check(32'(i_peer.last_members[3]), 32'h1);
         if (k.params) check(i_peer.last_param, PP);
         next_frame();
      end
      check(32'(nb > 0), 32'h1);
      axi_rd(token_node_pkg::ADDR_STATUS);
      check(32'(rd[10]), 32'h1);
      summarize();
   end
   initial begin
      #200000;
      failures++;
      $display("ERROR %0t: watchdog expired", $time);
      summarize();
   end
endmodule : tb_token_bus_node_control
`default_nettype wire
